//--- ettu_pkg.sv
// package of the emulator trace and trigger unit: register map, fields, types
// assumes a 125 MHz pclk and one target cycle marked per strobe
package ettu_pkg;
	// =========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ADDR1 = 8'h04;
	localparam logic [7:0] OFS_ADDR2 = 8'h08;
	localparam logic [7:0] OFS_SEQ = 8'h0C;
	localparam logic [7:0] OFS_TLOAD = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;
	localparam logic [7:0] OFS_TIDX = 8'h1C;
	localparam logic [7:0] OFS_TLO = 8'h20;
	localparam logic [7:0] OFS_THI = 8'h24;
	localparam logic [7:0] OFS_STATE = 8'h28;
	// =========================================================
	// status bit positions (same layout in mask)
	localparam int STS_TP = 0;
	localparam int STS_DONE = 1;
	localparam int STS_TBRK = 2;
	// =========================================================
	// buffer and timing
	localparam int DEPTH = 32768;
	localparam int AW = 15;
	localparam logic [15:0] POST_FULL = 16'h8000;
	localparam logic [15:0] POST_HALF = 16'h4000;
	localparam int CLK_PERIOD_NS = 8;
	localparam int TIMER_TICK_NS = 10000;
	localparam int TICK_CYCLES = (TIMER_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [10:0] TICK_LAST = 11'(TICK_CYCLES - 1);
	// =========================================================
	// reset values
	localparam logic [15:0] TLOAD_RST = 16'h0002;
	localparam logic [15:0] ADDR_RST = 16'h0000;
	// =========================================================
	// modes
	typedef enum logic [1:0] {CMB_AND = 2'h0, CMB_OR = 2'h1, CMB_SEQ = 2'h2} ettu_cmb_t;
	typedef enum logic [1:0] {
		RNG_BEFORE_BREAK = 2'h0, RNG_BEFORE_TRACE = 2'h1,
		RNG_ABOUT_TRACE = 2'h2, RNG_AFTER_TRACE = 2'h3
	} ettu_rng_t;
	typedef enum logic [1:0] {
		TMR_TIMER_OFF = 2'h0, TMR_DEADLINE = 2'h1,
		TMR_RUN_TIME_LIMIT = 2'h2, TMR_POST_BREAK_DELAY = 2'h3
	} ettu_tmr_t;
	// sequence slot codes: 0 none, 1 address_event_one, 2 address_event_two, 3 trigger
	localparam logic [1:0] SLOT_NONE = 2'h0;
	typedef enum logic [3:0] {
		CAP_IDLE = 4'h1, CAP_RUN = 4'h2, CAP_POST = 4'h4, CAP_DONE = 4'h8
	} ettu_cap_t;
	// =========================================================
	// carriers
	typedef struct packed {
		logic time_src;   // 1: fixed 10us ticks, 0: target cycles
		ettu_tmr_t tmode;
		ettu_rng_t range;
		logic trig_high;  // trigger event active level
		logic [2:0] en;   // {trigger, address_event_two, address_event_one}
		ettu_cmb_t cmb;
	} ettu_ctrl_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [9:0] data;
		logic [3:0] areg;
		logic skip;
		logic intr;
		logic stk_fault;
		logic [3:0] probe;    // probe_input_zero .. probe_input_three
	} ettu_rec_t;
	typedef struct packed {
		logic paddr_ok;
		logic [7:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} ettu_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ettu_apb_rsp_t;
endpackage : ettu_pkg

//--- ettu_top.sv
// emulator trace and trigger unit: trace capture, event combination, break timer
// assumes target inputs are synchronous to pclk and tgt_valid marks one traced cycle
//
// Function
// R1: record address, data and accumulator per cycle
// R2: skip marker set for skipped instruction
// R3: interrupt marker set when interrupt occurred
// R4: stack fault marker on overflow or underflow
// R5: sample four probe inputs every traced cycle
// R6: AND needs all enabled, OR any
// R7: sequential fires after events in order
// R8: before-break keeps last 32K before stop
// R9: before-trace keeps 32K before stop
// R10: about-trace keeps 32K around trace point
// R11: after-trace keeps 32K after trace point
// R12: timer off gives no timer break
// R13: deadline breaks if no breakpoint in time
// R14: run limit breaks after time from start
// R15: post delay breaks after time past breakpoint
// R16: time source ticks every 10us
// R17: cycle source ticks every target cycle
// R18: circular 32K buffer, freezes at range end
// R19: address events are equality compares
//
// Added by the designer: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module ettu_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire ettu_pkg::ettu_apb_req_t apb_req,
	output ettu_pkg::ettu_apb_rsp_t apb_rsp,
	input wire logic tgt_valid,
	input wire ettu_pkg::ettu_rec_t tgt_rec,
	input wire logic trig_in,
	input wire logic prog_running,
	input wire logic bp_hit,
	output logic brk_req,
	output logic irq
);
	import ettu_pkg::*;

	typedef struct packed {
		ettu_ctrl_t ctrl;
		logic [15:0] addr1;
		logic [15:0] addr2;
		logic [5:0] seq;
		logic [15:0] tload;
		logic [2:0] sts;
		logic [2:0] msk;
		logic [AW-1:0] tidx;
		logic [31:0] prdata;
		logic pslverr;
		ettu_cap_t cap;
		logic [AW-1:0] wptr;
		logic filled;
		logic [15:0] post_cnt;
		logic [1:0] step;
		logic run_q;
		logic tmr_on;
		logic [15:0] tmr_cnt;
		logic [10:0] presc;
		logic brk;
	} ettu_state_t;

	ettu_state_t st_r;
	ettu_state_t st_nxt;
	ettu_rec_t mem [DEPTH];
	ettu_rec_t rd_rec;
	logic ev1;
	logic ev2;
	logic evt;
	logic tp;
	logic go_rise;
	logic stop_fall;
	logic capturing;
	logic tick;
	logic wr_en;
	logic rd_en;
	logic [2:0] w1c;
	logic [2:0] sts_set;
	logic [2:0] evv;
	logic [1:0] slot;
	logic [1:0] next_slot;
	logic seq_hit;

	// =========================================================
	// event detection
	assign ev1 = tgt_valid && (tgt_rec.addr == st_r.addr1); // R19
	assign ev2 = tgt_valid && (tgt_rec.addr == st_r.addr2); // R19
	assign evt = tgt_valid && (trig_in == st_r.ctrl.trig_high);
	assign evv = {evt, ev2, ev1};
	assign go_rise = prog_running && !st_r.run_q;
	assign stop_fall = !prog_running && st_r.run_q;
	assign capturing = (st_r.cap == CAP_RUN) || (st_r.cap == CAP_POST);

	// the slot after the current one tells whether this step is the last
	assign slot = st_r.seq[2*st_r.step +: 2];
	assign next_slot = (st_r.step == 2'h2) ? SLOT_NONE : st_r.seq[2*(st_r.step+2'h1) +: 2];
	assign seq_hit = (slot != SLOT_NONE) && evv[slot - 2'h1];

	always_comb begin
		unique case (st_r.ctrl.cmb)
			CMB_AND: tp = tgt_valid && (st_r.ctrl.en != 3'h0)
				&& ((evv & st_r.ctrl.en) == st_r.ctrl.en); // R6
			CMB_OR: tp = |(evv & st_r.ctrl.en); // R6
			CMB_SEQ: tp = seq_hit && (next_slot == SLOT_NONE); // R7
			default: tp = 1'b0;
		endcase
	end

	assign tick = st_r.ctrl.time_src ? (st_r.presc == TICK_LAST) : tgt_valid; // R16 R17

	// =========================================================
	// apb decode
	assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd_en = apb_req.psel && !apb_req.penable && !apb_req.pwrite;
	assign w1c = (wr_en && apb_req.paddr == OFS_STATUS) ? apb_req.pwdata[2:0] : 3'h0;
	assign rd_rec = mem[st_r.tidx];
	assign apb_rsp.prdata = st_r.prdata;
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = st_r.pslverr && apb_req.penable;

	// =========================================================
	// trace storage; kept out of the state struct since it holds data only
	always_ff @(posedge pclk) begin
		if (capturing && tgt_valid) begin
			mem[st_r.wptr] <= tgt_rec; // R1 R2 R3 R4 R5 R18
		end
	end

	// =========================================================
	// next state
	always_comb begin
		st_nxt = st_r;
		st_nxt.run_q = prog_running;
		st_nxt.brk = 1'b0;
		sts_set = 3'h0;

		// register writes
		if (wr_en) begin
			unique case (apb_req.paddr)
				OFS_CTRL: st_nxt.ctrl = ettu_ctrl_t'(apb_req.pwdata[10:0]);
				OFS_ADDR1: st_nxt.addr1 = apb_req.pwdata[15:0];
				OFS_ADDR2: st_nxt.addr2 = apb_req.pwdata[15:0];
				OFS_SEQ: st_nxt.seq = apb_req.pwdata[5:0];
				OFS_TLOAD: st_nxt.tload = apb_req.pwdata[15:0];
				OFS_MASK: st_nxt.msk = apb_req.pwdata[2:0];
				OFS_TIDX: st_nxt.tidx = apb_req.pwdata[AW-1:0];
				default: st_nxt.ctrl = st_r.ctrl;
			endcase
		end

		// register reads, latched in the setup cycle
		if (apb_req.psel && !apb_req.penable) begin
			st_nxt.pslverr = !(apb_req.paddr <= OFS_STATE && apb_req.paddr[1:0] == 2'h0);
		end
		if (rd_en) begin
			unique case (apb_req.paddr)
				OFS_CTRL: st_nxt.prdata = {21'h0, st_r.ctrl};
				OFS_ADDR1: st_nxt.prdata = {16'h0, st_r.addr1};
				OFS_ADDR2: st_nxt.prdata = {16'h0, st_r.addr2};
				OFS_SEQ: st_nxt.prdata = {26'h0, st_r.seq};
				OFS_TLOAD: st_nxt.prdata = {16'h0, st_r.tload};
				OFS_STATUS: st_nxt.prdata = {29'h0, st_r.sts};
				OFS_MASK: st_nxt.prdata = {29'h0, st_r.msk};
				OFS_TIDX: st_nxt.prdata = {17'h0, st_r.tidx};
				OFS_TLO: st_nxt.prdata = {2'h0, rd_rec.areg, rd_rec.data, rd_rec.addr};
				OFS_THI: st_nxt.prdata = {25'h0, rd_rec.probe, rd_rec.stk_fault,
					rd_rec.intr, rd_rec.skip};
				OFS_STATE: st_nxt.prdata = {st_r.tmr_on, st_r.filled, st_r.cap,
					st_r.wptr[11:0], 1'b0, st_r.wptr[AW-1:12], 10'h0};
				default: st_nxt.prdata = 32'h0;
			endcase
		end

		// sequential stepping restarts after a completed sequence
		if (st_r.ctrl.cmb == CMB_SEQ && seq_hit) begin
			st_nxt.step = (next_slot == SLOT_NONE) ? 2'h0 : st_r.step + 2'h1; // R7
		end
		if (go_rise) begin
			st_nxt.step = 2'h0;
		end
		if (tp) begin
			sts_set[STS_TP] = 1'b1;
		end

		// capture
		if (capturing && tgt_valid) begin
			st_nxt.wptr = st_r.wptr + 15'h1; // R18
			if (st_r.wptr == 15'h7FFF) begin
				st_nxt.filled = 1'b1;
			end
		end
		unique case (st_r.cap)
			CAP_IDLE, CAP_DONE: begin
				if (go_rise) begin
					st_nxt.cap = CAP_RUN;
					st_nxt.wptr = 15'h0;
					st_nxt.filled = 1'b0;
				end
			end
			CAP_RUN: begin
				if (stop_fall) begin
					st_nxt.cap = CAP_DONE; // R8 R9
					sts_set[STS_DONE] = 1'b1;
				end else if (tp && st_r.ctrl.range == RNG_ABOUT_TRACE) begin
					st_nxt.cap = CAP_POST; // R10
					st_nxt.post_cnt = POST_HALF;
				end else if (tp && st_r.ctrl.range == RNG_AFTER_TRACE) begin
					st_nxt.cap = CAP_POST; // R11
					st_nxt.post_cnt = POST_FULL;
					st_nxt.filled = 1'b0;
				end
			end
			CAP_POST: begin
				if (tgt_valid) begin
					st_nxt.post_cnt = st_r.post_cnt - 16'h1;
				end
				if (stop_fall || (tgt_valid && st_r.post_cnt == 16'h1)) begin
					st_nxt.cap = CAP_DONE; // R10 R11 R18
					sts_set[STS_DONE] = 1'b1;
				end
			end
			default: st_nxt.cap = CAP_IDLE;
		endcase

		// break timer
		st_nxt.presc = (st_r.presc == TICK_LAST) ? 11'h0 : st_r.presc + 11'h1; // R16
		unique case (st_r.ctrl.tmode)
			TMR_TIMER_OFF: st_nxt.tmr_on = 1'b0; // R12
			TMR_DEADLINE: begin
				if (go_rise) begin
					st_nxt.tmr_on = 1'b1; // R13
					st_nxt.tmr_cnt = st_r.tload;
				end else if (bp_hit || stop_fall) begin
					st_nxt.tmr_on = 1'b0; // R13
				end
			end
			TMR_RUN_TIME_LIMIT: begin
				if (go_rise) begin
					st_nxt.tmr_on = 1'b1; // R14
					st_nxt.tmr_cnt = st_r.tload;
				end else if (stop_fall) begin
					st_nxt.tmr_on = 1'b0;
				end
			end
			TMR_POST_BREAK_DELAY: begin
				if (bp_hit && !st_r.tmr_on) begin
					st_nxt.tmr_on = 1'b1; // R15
					st_nxt.tmr_cnt = st_r.tload;
				end else if (stop_fall) begin
					// a delay left over from a stopped run must not break the next one
					st_nxt.tmr_on = 1'b0; // R15
				end
			end
			default: st_nxt.tmr_on = 1'b0;
		endcase
		if (st_r.tmr_on && tick && st_nxt.tmr_on) begin
			if (st_r.tmr_cnt <= 16'h1) begin
				st_nxt.tmr_on = 1'b0;
				st_nxt.brk = 1'b1; // R13 R14 R15
				sts_set[STS_TBRK] = 1'b1;
			end else begin
				st_nxt.tmr_cnt = st_r.tmr_cnt - 16'h1; // R16 R17
			end
		end

		// a new event outweighs a clear in the same cycle
		st_nxt.sts = (st_r.sts & ~w1c) | sts_set;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= '{ctrl: '{time_src: 1'b1, tmode: TMR_TIMER_OFF, range: RNG_BEFORE_BREAK,
				trig_high: 1'b1, en: 3'h0, cmb: CMB_AND},
				addr1: ADDR_RST, addr2: ADDR_RST, tload: TLOAD_RST, cap: CAP_IDLE,
				default: '0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign brk_req = st_r.brk;
	assign irq = |(st_r.sts & st_r.msk);

	// =========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_rec_advance: assert property (capturing && tgt_valid |=> // R18
		st_r.wptr == $past(st_r.wptr) + 15'h1) else $error("write pointer did not advance");
	a_frozen_done: assert property (st_r.cap == CAP_DONE && !go_rise |=> // R18
		$stable(st_r.wptr)) else $error("buffer moved after freeze");
	a_and_all: assert property (st_r.ctrl.cmb == CMB_AND && st_r.ctrl.en == 3'h3 // R6
		&& ev1 && !ev2 |-> !tp) else $error("and fired on partial match");
	a_or_any: assert property (st_r.ctrl.cmb == CMB_OR && st_r.ctrl.en[0] && ev1 // R6
		|-> tp) else $error("or missed an enabled event");
	a_about_half: assert property (st_r.cap == CAP_RUN && !stop_fall && tp // R10
		&& st_r.ctrl.range == RNG_ABOUT_TRACE |=> st_r.cap == CAP_POST
		&& st_r.post_cnt == POST_HALF) else $error("about range not half window");
	a_timer_off: assert property (st_r.ctrl.tmode == TMR_TIMER_OFF // R12
		&& $past(st_r.ctrl.tmode) == TMR_TIMER_OFF |-> !brk_req)
		else $error("break while timer off");
	a_post_start: assert property (st_r.ctrl.tmode == TMR_POST_BREAK_DELAY && bp_hit // R15
		&& !st_r.tmr_on |=> st_r.tmr_on && st_r.tmr_cnt == $past(st_r.tload))
		else $error("post delay did not start");
	a_tick_period: assert property (st_r.presc == TICK_LAST |=> // R16
		st_r.presc == 11'h0 ##1 st_r.presc == 11'h1) else $error("prescaler wrap wrong");
	a_deadline_cancel: assert property (st_r.ctrl.tmode == TMR_DEADLINE && bp_hit // R13
		&& !go_rise |=> !st_r.tmr_on ##1 !brk_req) else $error("deadline not cancelled");

	// =========================================================
	// record, capture window, event status, sequence and timer checks
	// timer count checks leave out stop edges, where cancel takes priority; a tick on a running timer overrides a go reload
	a_rec_store: assert property (capturing && tgt_valid |=> // R1
		mem[$past(st_r.wptr)] == $past(tgt_rec)) else $error("trace record not stored");
	a_run_start: assert property (st_r.cap inside {CAP_IDLE, CAP_DONE} && go_rise // R18
		|=> st_r.cap == CAP_RUN && st_r.wptr == 15'h0) else $error("capture did not restart");
	a_stop_freeze: assert property (st_r.cap == CAP_RUN && stop_fall |=> // R8
		st_r.cap == CAP_DONE && st_r.sts[STS_DONE]) else $error("capture not frozen at stop");
	a_after_full: assert property (st_r.cap == CAP_RUN && !stop_fall && tp // R11
		&& st_r.ctrl.range == RNG_AFTER_TRACE |=> st_r.cap == CAP_POST
		&& st_r.post_cnt == POST_FULL) else $error("after range not full window");
	a_post_end: assert property (st_r.cap == CAP_POST && tgt_valid // R10
		&& st_r.post_cnt == 16'h1 |=> st_r.cap == CAP_DONE) else $error("window did not close");
	a_tp_status: assert property (tp |=> st_r.sts[STS_TP]) // R6
		else $error("trace point not recorded");
	a_seq_restart: assert property (st_r.ctrl.cmb == CMB_SEQ && tp && !go_rise // R7
		|=> st_r.step == 2'h0) else $error("sequence did not restart");
	a_deadline_start: assert property (st_r.ctrl.tmode == TMR_DEADLINE && go_rise // R13
		&& !st_r.tmr_on |=> st_r.tmr_on && st_r.tmr_cnt == $past(st_r.tload))
		else $error("deadline did not start");
	a_limit_start: assert property (st_r.ctrl.tmode == TMR_RUN_TIME_LIMIT && go_rise // R14
		&& !st_r.tmr_on |=> st_r.tmr_on && st_r.tmr_cnt == $past(st_r.tload))
		else $error("run limit did not start");
	a_limit_expire: assert property (st_r.ctrl.tmode == TMR_RUN_TIME_LIMIT && st_r.tmr_on // R14
		&& tick && !stop_fall && st_r.tmr_cnt == 16'h1 |=> brk_req)
		else $error("run limit did not break");
	a_post_cancel: assert property (st_r.ctrl.tmode == TMR_POST_BREAK_DELAY && stop_fall // R15
		&& !bp_hit |=> !st_r.tmr_on) else $error("post delay survived stop");
	a_cycle_tick: assert property (!st_r.ctrl.time_src && st_r.tmr_on && st_nxt.tmr_on // R17
		&& tgt_valid && !go_rise && st_r.tmr_cnt > 16'h1 |=>
		st_r.tmr_cnt == $past(st_r.tmr_cnt) - 16'h1) else $error("cycle tick not counted");
endmodule : ettu_top
`default_nettype wire

//--- ettu_tgt_model.sv
// target core model: traced cycles, run state, breakpoint pulses, trigger level
// assumes pclk comes from the bench; its tasks are called hierarchically
`timescale 1ns/100ps
`default_nettype none
module ettu_tgt_model (
	input wire logic pclk,
	output logic tgt_valid,
	output ettu_pkg::ettu_rec_t tgt_rec,
	output logic trig_in,
	output logic prog_running,
	output logic bp_hit
);
	import ettu_pkg::*;
	initial begin
		tgt_valid = 1'b0;
		tgt_rec = '1;
		trig_in = 1'b0;
		prog_running = 1'b0;
		bp_hit = 1'b0;
	end
	// ==========
	// cycles
	// lines are inverted between cycles so that stale values are never read as fresh
	task step(input ettu_rec_t r, input logic t, input int gap);
		@(posedge pclk);
		tgt_valid <= 1'b1;
		tgt_rec <= r;
		trig_in <= t;
		@(posedge pclk);
		tgt_valid <= 1'b0;
		tgt_rec <= ~r;
		trig_in <= ~t;
		repeat (gap) @(posedge pclk);
	endtask : step
	task burst(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			tgt_valid <= 1'b1;
			tgt_rec <= ettu_rec_t'({16'(i), 21'h0});
		end
		@(posedge pclk);
		tgt_valid <= 1'b0;
		tgt_rec <= '1;
	endtask : burst
	task set_run(input logic on);
		@(posedge pclk);
		prog_running <= on;
	endtask : set_run
	task pulse_bp();
		@(posedge pclk);
		bp_hit <= 1'b1;
		@(posedge pclk);
		bp_hit <= 1'b0;
	endtask : pulse_bp
endmodule : ettu_tgt_model
`default_nettype wire

//--- tb_top.sv
// bench: register, capture, trigger and break timer tests of the trace unit
// assumes ettu_top and the target core model are compiled alongside
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import ettu_pkg::*;
	logic pclk, presetn, brk_req, irq, tv, ti, prun, bp, e;
	ettu_apb_req_t rq;
	ettu_apb_rsp_t rs;
	ettu_rec_t tr;
	logic [31:0] r;
	int n_errors = 0, cmp_count = 0, n_brk = 0, b0;
	ettu_rec_t recs [3] = '{
		'{16'h05F6, 10'h281, 4'hF, 1'b0, 1'b1, 1'b0, 4'hA},
		'{16'h05F7, 10'h0EB, 4'h3, 1'b1, 1'b0, 1'b1, 4'h5},
		'{16'hFFFF, 10'h3FF, 4'h0, 1'b1, 1'b1, 1'b0, 4'hF}};
	logic [11:0] ec [8] = '{12'h2C, 12'h34, 12'h34, 12'h2D, 12'h2D, 12'h11, 12'h11, 12'h2D};
	logic [15:0] ea [8] = '{16'h100, 16'h100, 16'h100, 16'h101, 16'h200, 16'h0, 16'h0, 16'h100};
	logic et [8] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic ex [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
	ettu_top ettu_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs),
		.tgt_valid(tv), .tgt_rec(tr), .trig_in(ti), .prog_running(prun), .bp_hit(bp),
		.brk_req(brk_req), .irq(irq));
	ettu_tgt_model ettu_tgt_model_inst (.pclk(pclk), .tgt_valid(tv), .tgt_rec(tr),
		.trig_in(ti), .prog_running(prun), .bp_hit(bp));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk) if (brk_req === 1'b1) n_brk <= n_brk + 1;
	// ==========
	// access tasks
	task chk(input logic [31:0] s, input logic [31:0] x);
		cmp_count++;
		if (s !== x) begin
			n_errors++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask : chk
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		rq <= '{paddr_ok: 1'b0, paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
		@(posedge pclk);
		rq.penable <= 1'b1;
		// no wait-state count is assumed; only the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (rs.pready !== 1'b1);
		r = rs.prdata;
		e = rs.pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
	endtask : apb
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(r & m, x);
	endtask : rdc
	task run(input logic on);
		ettu_tgt_model_inst.set_run(on);
	endtask : run
	task stp(input logic [15:0] a, input logic t);
		ettu_tgt_model_inst.step(ettu_rec_t'({a, 21'h0}), t, 0);
	endtask : stp
	// counts timer breaks over one run with a load of five
	task tmr(input logic [31:0] c, input int pre, input int b, input int post, input int x);
		wr(OFS_CTRL, c);
		wr(OFS_TLOAD, 32'h5);
		run(1'b1);
		b0 = n_brk;
		repeat (pre) stp(16'h0, 1'b0);
		if (b != 0) ettu_tgt_model_inst.pulse_bp();
		repeat (post) stp(16'h0, 1'b0);
		repeat (4) @(posedge pclk);
		chk(n_brk - b0, x);
		run(1'b0);
	endtask : tmr
	task finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	initial begin
		repeat (90000) @(posedge pclk);
		n_errors++;
		finish_test();
	end
	// ==========
	// tests
	initial begin
		presetn = 1'b0;
		rq = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rdc(OFS_CTRL, 32'hFFFFFFFF, 32'h420);
		rdc(OFS_TLOAD, 32'hFFFFFFFF, 32'h2);
		rdc(8'h2C, 32'hFFFFFFFF, 32'h0);
		chk({31'h0, e}, 32'h1);
		$display("reset and map test done");
		for (int g = 0; g < 2; g++) begin
			wr(OFS_STATUS, 32'h7);
			wr(OFS_CTRL, 32'h20 | (g << 6));
			run(1'b1);
			for (int i = 0; i < 3; i++) ettu_tgt_model_inst.step(recs[i], 1'b0, i);
			rdc(OFS_STATUS, 32'h2, 32'h0);
			run(1'b0);
			rdc(OFS_STATUS, 32'h2, 32'h2);
			for (int i = 0; i < 3; i++) begin
				wr(OFS_TIDX, 32'(i));
				rdc(OFS_TLO, '1, {2'h0, recs[i].areg, recs[i].data, recs[i].addr});
				rdc(OFS_THI, '1, {25'h0, recs[i].probe, recs[i].stk_fault, recs[i].intr,
					recs[i].skip});
			end
		end
		$display("capture test done");
		wr(OFS_ADDR1, 32'h100);
		wr(OFS_ADDR2, 32'h200);
		for (int k = 0; k < 8; k++) begin
			wr(OFS_STATUS, 32'h7);
			wr(OFS_CTRL, {20'h0, ec[k]});
			run(1'b1);
			stp(ea[k], et[k]);
			rdc(OFS_STATUS, 32'h1, {31'h0, ex[k]});
			run(1'b0);
		end
		wr(OFS_STATUS, 32'h7);
		wr(OFS_SEQ, 32'h9);
		wr(OFS_CTRL, 32'h2E);
		run(1'b1);
		stp(16'h200, 1'b0);
		rdc(OFS_STATUS, 32'h1, 32'h0);
		stp(16'h100, 1'b0);
		rdc(OFS_STATUS, 32'h1, 32'h0);
		stp(16'h200, 1'b0);
		rdc(OFS_STATUS, 32'h1, 32'h1);
		run(1'b0);
		wr(OFS_MASK, 32'h1);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_STATUS, 32'h1);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		$display("event test done");
		tmr(32'h020, 8, 0, 0, 0);
		tmr(32'h220, 4, 0, 0, 0);
		tmr(32'h220, 5, 0, 0, 1);
		tmr(32'h120, 3, 1, 6, 0);
		tmr(32'h120, 5, 0, 0, 1);
		tmr(32'h320, 6, 1, 4, 0);
		tmr(32'h320, 6, 1, 5, 1);
		wr(OFS_MASK, 32'h4);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h1);
		wr(OFS_TLOAD, 32'h2);
		wr(OFS_CTRL, 32'h620);
		run(1'b1);
		b0 = n_brk;
		repeat (1240) @(posedge pclk);
		chk(n_brk - b0, 0);
		repeat (1300) @(posedge pclk);
		chk(n_brk - b0, 1);
		run(1'b0);
		$display("timer test done");
		for (int g = 0; g < 2; g++) begin
			wr(OFS_CTRL, g ? 32'hF1 : 32'hB1);
			wr(OFS_STATUS, 32'h7);
			run(1'b1);
			stp(16'h0, 1'b1);
			ettu_tgt_model_inst.burst(g ? 32766 : 16382);
			rdc(OFS_STATUS, 32'h2, 32'h0);
			ettu_tgt_model_inst.burst(2);
			rdc(OFS_STATUS, 32'h2, 32'h2);
			run(1'b0);
		end
		$display("range test done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
